//--- logic/cdco_core.v
`timescale 1ns/1ps
`include "cdco_regs.vh"

// Behaviour
// RL1 - Kick clears watchdog counter and prescaler
// RL2 - Kick sets expiry and sleep flags only
// RL3 - Call via accumulator pushes PC plus one
// RL4 - Then PC gets latch bits and accumulator
// RL5 - Call takes two cycles, flags untouched
// RL6 - Invert register to accumulator or register
// RL7 - Zero register, set null flag
// RL8 - Decrement to destination, update null flag
// RL9 - Zero accumulator, set null flag
// RL10 - Countdown decrements to destination, flags untouched
// RL11 - Zero countdown result discards next instruction
// RL12 - Null flag equals result equals zero
module cdco_core (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         wdog_clear_q,
    output reg         stack_push_q,
    output reg  [14:0] stack_top_entry_q
);

    localparam S_IDLE  = 2'h0;
    localparam S_READ  = 2'h1;
    localparam S_EXEC  = 2'h2;
    localparam S_CALL2 = 2'h3;

    // ------------------------------------------------------------------------
    // Decoding and byte-lane helpers
    // ------------------------------------------------------------------------
    function [3:0] cdco_sel;
        input [5:0] addr;
        begin
            case (addr)
                `CDCO_OFF_CTRL:   cdco_sel = `CDCO_SEL_CTRL;
                `CDCO_OFF_ACCUM:  cdco_sel = `CDCO_SEL_ACCUM;
                `CDCO_OFF_STATUS: cdco_sel = `CDCO_SEL_STATUS;
                `CDCO_OFF_PC:     cdco_sel = `CDCO_SEL_PC;
                `CDCO_OFF_UPCL:   cdco_sel = `CDCO_SEL_UPCL;
                `CDCO_OFF_STACK:  cdco_sel = `CDCO_SEL_STACK;
                `CDCO_OFF_FADDR:  cdco_sel = `CDCO_SEL_FADDR;
                `CDCO_OFF_FDATA:  cdco_sel = `CDCO_SEL_FDATA;
                `CDCO_OFF_CYCLES: cdco_sel = `CDCO_SEL_CYCLES;
                default:          cdco_sel = `CDCO_SEL_NONE;
            endcase
        end
    endfunction

    function [31:0] cdco_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      i;
        begin
            cdco_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    cdco_merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [10:0] ctrl_q;
    reg  [7:0]  accum_q;
    reg  [7:0]  status_q;
    reg  [14:0] pc_q;
    reg  [6:0]  upper_pc_latch_q;
    reg  [6:0]  faddr_q;
    reg  [31:0] cycles_q;
    reg         skip_pending_q;
    reg         have_aw_q;
    reg         have_w_q;
    reg  [5:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg  [5:0]  araddr_q;
    reg         rd_stage_q;
    reg  [7:0]  res_d;
    reg  [31:0] rd_word_d;

    wire [7:0]  mem_rdata;
    wire [7:0]  inv_w;
    wire [2:0]  op_w      = ctrl_q[`CDCO_CTRL_OP_LSB +: 3];
    wire        dest_w    = ctrl_q[`CDCO_CTRL_DEST_BIT];
    wire [6:0]  f_w       = ctrl_q[`CDCO_CTRL_F_LSB +: 7];
    wire [3:0]  wsel_w    = cdco_sel(awaddr_q);
    wire [3:0]  rsel_w    = cdco_sel(araddr_q);
    wire [31:0] merged_w;
    wire        ar_hs     = s_axi_arvalid & s_axi_arready;
    wire        aw_hs     = s_axi_awvalid & s_axi_awready;
    wire        w_hs      = s_axi_wvalid & s_axi_wready;
    wire        wr_fire   = have_aw_q & have_w_q & ~s_axi_bvalid & (state_q == S_IDLE)
                            & ~rd_stage_q & ~s_axi_rvalid & ~ar_hs;
    wire        rvalid_d  = rd_stage_q | (s_axi_rvalid & ~s_axi_rready);
    wire        issue_w   = wr_fire & (wsel_w == `CDCO_SEL_CTRL);
    wire        file_op_w = (op_w == `CDCO_OP_INVERT) | (op_w == `CDCO_OP_MINUS_ONE)
                            | (op_w == `CDCO_OP_SKIP);
    wire        exec_w    = (state_q == S_EXEC);
    wire        exec_we   = exec_w & ((file_op_w & dest_w) | (op_w == `CDCO_OP_ZERO_REG));
    wire        sw_we     = wr_fire & (wsel_w == `CDCO_SEL_FDATA) & wstrb_q[0];
    wire        res_null  = (res_d == `CDCO_ZERO_BYTE);

    // Old value of the addressed register for partial-strobe writes.
    reg  [31:0] wr_old_d;
    always @* begin
        wr_old_d = 32'h00000000;
        case (wsel_w)
            `CDCO_SEL_CTRL:   wr_old_d = {21'h00000, ctrl_q};
            `CDCO_SEL_ACCUM:  wr_old_d = {24'h000000, accum_q};
            `CDCO_SEL_STATUS: wr_old_d = {24'h000000, status_q};
            `CDCO_SEL_PC:     wr_old_d = {17'h0000, pc_q};
            `CDCO_SEL_UPCL:   wr_old_d = {25'h000000, upper_pc_latch_q};
            `CDCO_SEL_FADDR:  wr_old_d = {25'h000000, faddr_q};
            default:          wr_old_d = 32'h00000000;
        endcase
    end
    assign merged_w = cdco_merge(wr_old_d, wdata_q, wstrb_q);

    // ------------------------------------------------------------------------
    // File register store
    // ------------------------------------------------------------------------
    cdco_file_mem u_mem (
        .aclk  (aclk),
        .we    (exec_we | sw_we),
        .waddr (exec_w ? f_w : faddr_q),
        .wdata (exec_w ? res_d : wdata_q[7:0]),
        .raddr ((state_q == S_READ) ? f_w : faddr_q),
        .rdata (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Result datapath
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_inv
            assign inv_w[gi] = ~mem_rdata[gi];
        end
    endgenerate

    always @* begin
        case (op_w)
            `CDCO_OP_INVERT:    res_d = inv_w;                 // see RL6
            `CDCO_OP_MINUS_ONE: res_d = mem_rdata - 8'h01;     // see RL8
            `CDCO_OP_SKIP:      res_d = mem_rdata - 8'h01;     // see RL10
            default:            res_d = `CDCO_ZERO_BYTE;       // see RL7
        endcase
    end

    always @* begin
        case (state_q)
            S_IDLE:  state_d = (issue_w & ~skip_pending_q) ? S_READ : S_IDLE;
            S_READ:  state_d = S_EXEC;
            S_EXEC:  state_d = (op_w == `CDCO_OP_CALL_VIA_ACCUM_OP) ? S_CALL2 : S_IDLE;
            S_CALL2: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @* begin
        case (rsel_w)
            `CDCO_SEL_CTRL:   rd_word_d = {19'h0000, skip_pending_q, (state_q != S_IDLE), ctrl_q};
            `CDCO_SEL_ACCUM:  rd_word_d = {24'h000000, accum_q};
            `CDCO_SEL_STATUS: rd_word_d = {24'h000000, status_q};
            `CDCO_SEL_PC:     rd_word_d = {17'h0000, pc_q};
            `CDCO_SEL_UPCL:   rd_word_d = {25'h000000, upper_pc_latch_q};
            `CDCO_SEL_STACK:  rd_word_d = {17'h0000, stack_top_entry_q};
            `CDCO_SEL_FADDR:  rd_word_d = {25'h000000, faddr_q};
            `CDCO_SEL_FDATA:  rd_word_d = {24'h000000, mem_rdata};
            `CDCO_SEL_CYCLES: rd_word_d = cycles_q;
            default:          rd_word_d = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Bus slave and execution sequencer
    // ------------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q           <= S_IDLE;
            ctrl_q            <= 11'h000;
            accum_q           <= `CDCO_RST_BYTE;
            status_q          <= `CDCO_RST_STATUS;
            pc_q              <= `CDCO_RST_PC;
            upper_pc_latch_q  <= 7'h00;
            faddr_q           <= 7'h00;
            cycles_q          <= 32'h00000000;
            skip_pending_q    <= 1'b0;
            have_aw_q         <= 1'b0;
            have_w_q          <= 1'b0;
            awaddr_q          <= 6'h00;
            wdata_q           <= 32'h00000000;
            wstrb_q           <= 4'h0;
            araddr_q          <= 6'h00;
            rd_stage_q        <= 1'b0;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `CDCO_RESP_OKAY;
            s_axi_arready     <= 1'b0;
            s_axi_rvalid      <= 1'b0;
            s_axi_rdata       <= 32'h00000000;
            s_axi_rresp       <= `CDCO_RESP_OKAY;
            wdog_clear_q      <= 1'b0;
            stack_push_q      <= 1'b0;
            stack_top_entry_q <= 15'h0000;
        end else begin
            wdog_clear_q <= 1'b0;
            stack_push_q <= 1'b0;
            state_q      <= state_d;

            // Address and data channels are captured independently.
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            have_aw_q     <= (have_aw_q | aw_hs) & ~wr_fire;
            have_w_q      <= (have_w_q | w_hs) & ~wr_fire;
            s_axi_awready <= ~((have_aw_q | aw_hs) & ~wr_fire);
            s_axi_wready  <= ~((have_w_q | w_hs) & ~wr_fire);
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wsel_w == `CDCO_SEL_NONE) ? `CDCO_RESP_SLVERR : `CDCO_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end

            // Reads answer two cycles after the address handshake, once the store has read out.
            if (ar_hs) begin
                araddr_q <= s_axi_araddr;
            end
            rd_stage_q    <= ar_hs;
            s_axi_rvalid  <= rvalid_d;
            s_axi_arready <= (state_d == S_IDLE) & ~ar_hs & ~rvalid_d;
            if (rd_stage_q) begin
                s_axi_rdata <= rd_word_d;
                s_axi_rresp <= (rsel_w == `CDCO_SEL_NONE) ? `CDCO_RESP_SLVERR : `CDCO_RESP_OKAY;
            end

            // Software register writes happen only while the sequencer is idle.
            if (wr_fire) begin
                case (wsel_w)
                    `CDCO_SEL_CTRL: begin
                        if (skip_pending_q) begin
                            skip_pending_q <= 1'b0;                        // see RL11
                            pc_q           <= pc_q + 15'h0001;
                            cycles_q       <= cycles_q + `CDCO_CYC_SINGLE;
                        end else begin
                            ctrl_q <= merged_w[10:0];
                        end
                    end
                    `CDCO_SEL_ACCUM:  accum_q          <= merged_w[7:0];
                    `CDCO_SEL_STATUS: status_q         <= merged_w[7:0];
                    `CDCO_SEL_PC:     pc_q             <= merged_w[14:0];
                    `CDCO_SEL_UPCL:   upper_pc_latch_q <= merged_w[6:0];
                    `CDCO_SEL_FADDR:  faddr_q          <= merged_w[6:0];
                    default: begin
                    end
                endcase
            end

            if (state_q == S_EXEC) begin
                case (op_w)
                    `CDCO_OP_KICK: begin
                        wdog_clear_q                 <= 1'b1;          // see RL1
                        status_q[`CDCO_ST_EXPIRY_BIT] <= 1'b1;         // see RL2
                        status_q[`CDCO_ST_SLEEP_BIT]  <= 1'b1;         // see RL2
                    end
                    `CDCO_OP_CALL_VIA_ACCUM_OP: begin
                        stack_push_q      <= 1'b1;                     // see RL3
                        stack_top_entry_q <= pc_q + 15'h0001;          // see RL3
                    end
                    `CDCO_OP_INVERT, `CDCO_OP_MINUS_ONE: begin
                        if (!dest_w) begin
                            accum_q <= res_d;                          // see RL6, RL8
                        end
                        status_q[`CDCO_ST_ZERO_BIT] <= res_null;       // see RL12
                    end
                    `CDCO_OP_ZERO_REG: begin
                        status_q[`CDCO_ST_ZERO_BIT] <= 1'b1;           // see RL7
                    end
                    `CDCO_OP_ZERO_ACCUM: begin
                        accum_q                     <= `CDCO_ZERO_BYTE; // see RL9
                        status_q[`CDCO_ST_ZERO_BIT] <= 1'b1;            // see RL9
                    end
                    `CDCO_OP_SKIP: begin
                        if (!dest_w) begin
                            accum_q <= res_d;                          // see RL10
                        end
                        skip_pending_q <= res_null;                    // see RL11
                    end
                    default: begin
                    end
                endcase
                if (op_w != `CDCO_OP_CALL_VIA_ACCUM_OP) begin
                    pc_q     <= pc_q + 15'h0001;
                    cycles_q <= cycles_q + `CDCO_CYC_SINGLE;
                end
            end

            if (state_q == S_CALL2) begin
                pc_q     <= {upper_pc_latch_q, accum_q};               // see RL4
                cycles_q <= cycles_q + `CDCO_CYC_DOUBLE;               // see RL5
            end
        end
    end

endmodule

//--- logic/cdco_file_mem.v
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// File register store, one write port and one registered read port
// ----------------------------------------------------------------------------
module cdco_file_mem (
    input  wire       aclk,
    input  wire       we,
    input  wire [6:0] waddr,
    input  wire [7:0] wdata,
    input  wire [6:0] raddr,
    output reg  [7:0] rdata
);

    reg [7:0] mem [0:127];

    always @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

//--- logic/cdco_regs.vh
`ifndef CDCO_REGS_VH
`define CDCO_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CDCO_OFF_CTRL      6'h00
`define CDCO_OFF_ACCUM     6'h04
`define CDCO_OFF_STATUS    6'h08
`define CDCO_OFF_PC        6'h0C
`define CDCO_OFF_UPCL      6'h10
`define CDCO_OFF_STACK     6'h14
`define CDCO_OFF_FADDR     6'h18
`define CDCO_OFF_FDATA     6'h1C
`define CDCO_OFF_CYCLES    6'h20

// ----------------------------------------------------------------------------
// Decoded register selects
// ----------------------------------------------------------------------------
`define CDCO_SEL_CTRL      4'h0
`define CDCO_SEL_ACCUM     4'h1
`define CDCO_SEL_STATUS    4'h2
`define CDCO_SEL_PC        4'h3
`define CDCO_SEL_UPCL      4'h4
`define CDCO_SEL_STACK     4'h5
`define CDCO_SEL_FADDR     4'h6
`define CDCO_SEL_FDATA     4'h7
`define CDCO_SEL_CYCLES    4'h8
`define CDCO_SEL_NONE      4'hF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CDCO_CTRL_OP_LSB   0
`define CDCO_CTRL_DEST_BIT 3
`define CDCO_CTRL_F_LSB    4
`define CDCO_CTRL_BUSY_BIT 11
`define CDCO_CTRL_SKIP_BIT 12
`define CDCO_ST_ZERO_BIT   2
`define CDCO_ST_SLEEP_BIT  3
`define CDCO_ST_EXPIRY_BIT 4

// ----------------------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------------------
`define CDCO_OP_NOP        3'h0
`define CDCO_OP_KICK       3'h1
`define CDCO_OP_CALL_VIA_ACCUM_OP      3'h2
`define CDCO_OP_INVERT     3'h3
`define CDCO_OP_ZERO_REG   3'h4
`define CDCO_OP_MINUS_ONE  3'h5
`define CDCO_OP_ZERO_ACCUM 3'h6
`define CDCO_OP_SKIP       3'h7

// ----------------------------------------------------------------------------
// Reset values, constants and cycle counts
// ----------------------------------------------------------------------------
`define CDCO_RST_BYTE      8'h00
`define CDCO_RST_STATUS    8'h18
`define CDCO_RST_PC        15'h0000
`define CDCO_ZERO_BYTE     8'h00
`define CDCO_CYC_SINGLE    32'h00000001
`define CDCO_CYC_DOUBLE    32'h00000002
`define CDCO_RESP_OKAY     2'h0
`define CDCO_RESP_SLVERR   2'h2

`endif

//--- test/cdco_core_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------------------
module cdco_core_sva (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        wdog_clear_q,
    input wire        stack_push_q,
    input wire [14:0] stack_top_entry_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_read_delay: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    chk_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready, 2))
        else $error("read answer without request");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:6] s_axi_bvalid) else $error("write answer late");
    chk_kick_pulse: assert property (wdog_clear_q |=> !wdog_clear_q)
        else $error("watchdog clear longer than one cycle");
    chk_push_pulse: assert property (stack_push_q |=> !stack_push_q)
        else $error("push longer than one cycle");
    chk_entry_on_push: assert property (!$stable(stack_top_entry_q) |-> stack_push_q)
        else $error("stack entry changed without push");
    chk_ops_apart: assert property (!(wdog_clear_q && stack_push_q))
        else $error("clear and push together");
    cov_push: cover property (stack_push_q);
    cov_kick: cover property (wdog_clear_q);
    cov_werr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    cov_rerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind cdco_core cdco_core_sva cdco_core_sva_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wdog_clear_q(wdog_clear_q), .stack_push_q(stack_push_q),
    .stack_top_entry_q(stack_top_entry_q));

//--- test/test_cpu_clear_decrement_call_ops.sv
`timescale 1ns/1ps
`include "cdco_regs.vh"
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module test_cpu_clear_decrement_call_ops;
    typedef struct packed {
        logic [2:0] op;
        logic       dest;
        logic [7:0] f;
        logic [7:0] acc;
        logic [7:0] st;
        logic [7:0] e_acc;
        logic [7:0] e_f;
        logic [7:0] e_st;
    } cdco_row_t;
    logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1;
    logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, pc0, cy0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        wdog_clear_q, stack_push_q;
    logic [14:0] stack_top_entry_q;
    int          err_total = 0, checks_done = 0, kicks = 0, pushes = 0, k0, i;
    cdco_row_t   rows [11];

    cdco_core cdco_core_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wdog_clear_q(wdog_clear_q), .stack_push_q(stack_push_q),
        .stack_top_entry_q(stack_top_entry_q));

    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        if (wdog_clear_q === 1'b1) kicks++;
        if (stack_push_q === 1'b1) pushes++;
    end

    task automatic final_report;
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] rs);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b0;
        rs = 2'h3;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
                rs = s_axi_bresp;
                break;
            end
            s_axi_bready <= s_axi_bvalid;
        end
    endtask

    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] rs);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b0;
        rs = 2'h3;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
                d = s_axi_rdata;
                rs = s_axi_rresp;
                break;
            end
            s_axi_rready <= s_axi_rvalid;
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        axw(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        axr(a, d, r);
        chk("rresp", 32'h0, {30'h0, r});
    endtask

    task automatic rchk(input string name, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask

    task automatic issue(input logic [2:0] op, input logic dest, input logic [6:0] fa);
        logic [31:0] c;
        wr(`CDCO_OFF_CTRL, {21'h0, fa, dest, op});
        for (int n = 0; n < 20; n++) begin
            rd(`CDCO_OFF_CTRL, c);
            if (c[11] === 1'b0) break;
        end
    endtask

    task automatic setup(input logic [6:0] fa, input logic [7:0] f, input logic [7:0] acc, input logic [7:0] st);
        wr(`CDCO_OFF_FADDR, {25'h0, fa});
        wr(`CDCO_OFF_FDATA, {24'h0, f});
        wr(`CDCO_OFF_ACCUM, {24'h0, acc});
        wr(`CDCO_OFF_STATUS, {24'h0, st});
        rd(`CDCO_OFF_PC, pc0);
        rd(`CDCO_OFF_CYCLES, cy0);
    endtask

    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        final_report;
    end

    initial begin
        rows[0] = '{`CDCO_OP_INVERT, 1'b0, 8'h5A, 8'h00, 8'h00, 8'hA5, 8'h5A, 8'h00};
        rows[1] = '{`CDCO_OP_INVERT, 1'b1, 8'hFF, 8'h11, 8'h00, 8'h11, 8'h00, 8'h04};
        rows[2] = '{`CDCO_OP_INVERT, 1'b0, 8'h00, 8'h00, 8'h04, 8'hFF, 8'h00, 8'h00};
        rows[3] = '{`CDCO_OP_ZERO_REG, 1'b1, 8'h37, 8'h22, 8'h00, 8'h22, 8'h00, 8'h04};
        rows[4] = '{`CDCO_OP_MINUS_ONE, 1'b0, 8'h01, 8'h33, 8'h00, 8'h00, 8'h01, 8'h04};
        rows[5] = '{`CDCO_OP_MINUS_ONE, 1'b1, 8'h00, 8'h44, 8'h04, 8'h44, 8'hFF, 8'h00};
        rows[6] = '{`CDCO_OP_ZERO_ACCUM, 1'b0, 8'h12, 8'h99, 8'h00, 8'h00, 8'h12, 8'h04};
        rows[7] = '{`CDCO_OP_KICK, 1'b0, 8'h12, 8'h55, 8'hE4, 8'h55, 8'h12, 8'hFC};
        rows[8] = '{`CDCO_OP_SKIP, 1'b0, 8'h05, 8'h77, 8'h04, 8'h04, 8'h05, 8'h04};
        rows[9] = '{`CDCO_OP_SKIP, 1'b1, 8'h00, 8'h88, 8'h04, 8'h88, 8'hFF, 8'h04};
        rows[10] = '{`CDCO_OP_NOP, 1'b1, 8'h3C, 8'h3C, 8'h08, 8'h3C, 8'h3C, 8'h08};
        do_reset;
        for (i = 0; i < 11; i++) begin
            setup(7'h7F - i[6:0], rows[i].f, rows[i].acc, rows[i].st);
            k0 = kicks;
            issue(rows[i].op, rows[i].dest, 7'h7F - i[6:0]);
            rchk("accum", `CDCO_OFF_ACCUM, {24'h0, rows[i].e_acc});
            rchk("file", `CDCO_OFF_FDATA, {24'h0, rows[i].e_f});
            rchk("status", `CDCO_OFF_STATUS, {24'h0, rows[i].e_st});
            rchk("pc", `CDCO_OFF_PC, (pc0 + 1) & 32'h7FFF);
            rchk("cycles", `CDCO_OFF_CYCLES, cy0 + 1);
            chk("kicks", (rows[i].op == `CDCO_OP_KICK) ? 1 : 0, kicks - k0);
        end
        // Call through the accumulator from just below the top of the program space.
        setup(7'h00, 8'h00, 8'hC3, 8'h14);
        wr(`CDCO_OFF_UPCL, 32'hDA);
        wr(`CDCO_OFF_PC, 32'h7FFE);
        k0 = pushes;
        issue(`CDCO_OP_CALL_VIA_ACCUM_OP, 1'b0, 7'h00);
        rchk("pc", `CDCO_OFF_PC, 32'h5AC3);
        rchk("stack", `CDCO_OFF_STACK, 32'h7FFF);
        chk("entry", 32'h7FFF, {17'h0, stack_top_entry_q});
        chk("pushes", 1, pushes - k0);
        rchk("status", `CDCO_OFF_STATUS, 32'h14);
        rchk("cycles", `CDCO_OFF_CYCLES, cy0 + 2);
        // A zero countdown result swallows the next instruction.
        setup(7'h21, 8'h01, 8'h66, 8'h00);
        issue(`CDCO_OP_SKIP, 1'b1, 7'h21);
        rchk("file", `CDCO_OFF_FDATA, 32'h00);
        rchk("status", `CDCO_OFF_STATUS, 32'h00);
        rd(`CDCO_OFF_CTRL, v);
        chk("skip", 32'h1, {31'h0, v[12]});
        issue(`CDCO_OP_MINUS_ONE, 1'b0, 7'h21);
        rchk("accum", `CDCO_OFF_ACCUM, 32'h66);
        rchk("pc", `CDCO_OFF_PC, (pc0 + 2) & 32'h7FFF);
        rchk("cycles", `CDCO_OFF_CYCLES, cy0 + 2);
        issue(`CDCO_OP_MINUS_ONE, 1'b0, 7'h21);
        rchk("accum", `CDCO_OFF_ACCUM, 32'hFF);
        // Unmapped places answer with an error.
        axw(6'h24, 32'hFFFFFFFF, r);
        chk("bresp", 32'h2, {30'h0, r});
        axr(6'h3C, v, r);
        chk("rresp", 32'h2, {30'h0, r});
        chk("rdata", 32'h0, v);
        do_reset;
        rchk("accum", `CDCO_OFF_ACCUM, 32'h0);
        rchk("status", `CDCO_OFF_STATUS, 32'h18);
        rchk("pc", `CDCO_OFF_PC, 32'h0);
        chk("entry", 32'h0, {17'h0, stack_top_entry_q});
        final_report;
    end
endmodule
